//--- rtl/fdcg_config.v
// floppy logical device configuration registers and irq/dma gating
// for the floppy, two serial ports and the parallel port.
// assumes index/data access on the core clock, one access per strobe,
// and requests from the device cores on the same clock.
`timescale 1ns/100ps
`include "fdcg_consts.vh"

// Overview of operation
// RL1 - floppy dma gate low blocks irq, dma
// RL2 - floppy powered down blocks irq, dma
// RL3 - serial aux output two low blocks irq
// RL4 - second port infrared dma gate blocks dma
// RL5 - spp/epp: printer irq gate low blocks irq
// RL6 - ecp: dma follows ecp dma gate always
// RL7 - ecr codes 010,011,110 irq on, else gated
// RL8 - vendor registers ignore soft reset
// RL9 - mode bit0 selects enhanced floppy mode
// RL10 - mode bit1 one selects non-burst dma
// RL11 - mode bits3:2 select interface mode
// RL12 - mode bit6 selects push-pull outputs
// RL13 - mode bit7 tri-states drive outputs
// RL14 - mode bit4 plain storage bit
// RL15 - forced write protect when any drive selected
// RL16 - write protect shown in status a bit1
// RL17 - option bits3:2 force density output
// RL18 - type register holds drive types, resets 0xff
// RL19 - index 0xf3 reads zero, read only
// RL20 - per-drive type, rate, zero bits
// RL21 - per-drive bit6 disables precompensation
// RL22 - second drive register mirrors first layout
// RL23 - irq needs nonzero select and local enable
// RL24 - dma needs select 1..3 and local enable
// RL25 - per-drive zero bits ignore writes
module fdcg_config (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       soft_rst,
    input  wire       cfg_sel,
    input  wire       cfg_wr,
    input  wire       cfg_rd,
    input  wire [7:0] cfg_index,
    input  wire [7:0] cfg_wdata,
    output reg  [7:0] cfg_rdata,
    output reg        cfg_rvalid,
    input  wire       floppy_dma_gate_bit,
    input  wire       floppy_powered_down,
    input  wire       floppy_irq_req,
    input  wire       floppy_dma_req,
    output reg        floppy_irq_out,
    output reg        floppy_dma_out,
    output reg  [3:0] floppy_irq_level,
    output reg  [2:0] floppy_dma_channel,
    input  wire [1:0] aux_output_two_bit,
    input  wire [1:0] serial_irq_req,
    output reg  [1:0] serial_irq_out,
    input  wire       ir_dma_gate_bit,
    input  wire       ir_dma_req,
    output reg        ir_dma_out,
    input  wire       pp_ecp_enabled,
    input  wire [2:0] ecr_mode,
    input  wire       printer_irq_gate_bit,
    input  wire       ecp_dma_gate_bit,
    input  wire       pp_irq_req,
    input  wire       pp_dma_req,
    output reg        pp_irq_out,
    output reg        pp_dma_out,
    input  wire       write_protect_in_n,
    input  wire       floppy_wp_bit,
    input  wire       drive_select_first_n,
    input  wire       drive_select_second_n,
    output reg        core_write_protect,
    output reg        floppy_status_a_wp,
    input  wire       density_core,
    output reg        density_out,
    input  wire [7:0] drive_out_core,
    output reg  [7:0] drive_out,
    output reg  [7:0] drive_out_oe,
    output reg        enhanced_mode,
    output reg        dma_non_burst,
    output reg  [1:0] interface_mode,
    output reg  [1:0] drive_type_a,
    output reg  [1:0] drive_type_b,
    output reg  [1:0] drive_type_sel_0,
    output reg  [1:0] rate_table_sel_0,
    output reg        precomp_disable_0,
    output reg  [1:0] drive_type_sel_1,
    output reg  [1:0] rate_table_sel_1,
    output reg        precomp_disable_1
);

    // vendor registers
    reg [7:0] floppy_mode_config;
    reg [7:0] floppy_option_config;
    reg [7:0] floppy_drive_type_store;
    reg [7:0] first_drive_settings;
    reg [7:0] second_drive_settings;

    // standard select registers, also reloaded with their reset values by soft reset
    reg [3:0] irq_select;
    reg [2:0] dma_select;

    wire       wr_hit;
    wire       wp_pin_n;
    reg  [7:0] next_rdata;
    reg        next_wp;
    reg        next_density;
    reg        pp_irq_enable;
    reg        irq_sel_ok;
    reg        dma_sel_ok;
    reg        fdc_local_on;
    wire [1:0] dens_code;

    assign wr_hit    = cfg_wr & cfg_sel;
    assign dens_code = floppy_option_config[`FDCG_OPT_DENS_HI:`FDCG_OPT_DENS_LO];

    // write protect pin is asynchronous to clk
    fdcg_sync #(
        .W    (1)
    ) u_wp_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .d    (write_protect_in_n),
        .init (1'b1),
        .q    (wp_pin_n)
    );

    // RL8 bus reset only
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            floppy_mode_config      <= `FDCG_RST_MODE;
            floppy_option_config    <= `FDCG_RST_OPTION;
            floppy_drive_type_store <= `FDCG_RST_TYPE;
            first_drive_settings    <= `FDCG_RST_DRIVE;
            second_drive_settings   <= `FDCG_RST_DRIVE;
        end else if (ce && wr_hit) begin
            case (cfg_index)
                // RL9 mode register storage
                // RL14 bit4 kept as written
                `FDCG_IDX_MODE: begin
                    floppy_mode_config <= cfg_wdata;
                end
                `FDCG_IDX_OPTION: begin
                    floppy_option_config <= cfg_wdata;
                end
                // RL18 all eight bits stored
                `FDCG_IDX_TYPE: begin
                    floppy_drive_type_store <= cfg_wdata;
                end
                // RL25 zero bits masked
                `FDCG_IDX_DRIVE0: begin
                    first_drive_settings <= cfg_wdata & `FDCG_DRIVE_WMASK;
                end
                // RL22 same mask as first
                `FDCG_IDX_DRIVE1: begin
                    second_drive_settings <= cfg_wdata & `FDCG_DRIVE_WMASK;
                end
                default: begin
                    floppy_mode_config <= floppy_mode_config;
                end
            endcase
        end
    end

    // select registers follow soft reset as well as bus reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_select <= `FDCG_RST_IRQ_SEL;
            dma_select <= `FDCG_RST_DMA_SEL;
        end else if (ce) begin
            if (soft_rst) begin
                irq_select <= `FDCG_RST_IRQ_SEL;
                dma_select <= `FDCG_RST_DMA_SEL;
            end else if (wr_hit && cfg_index == `FDCG_IDX_IRQ_SEL) begin
                irq_select <= cfg_wdata[3:0];
            end else if (wr_hit && cfg_index == `FDCG_IDX_DMA_SEL) begin
                dma_select <= cfg_wdata[2:0];
            end
        end
    end

    // read data mux; upper bits of select registers read zero
    always @* begin
        next_rdata = 8'h00;
        case (cfg_index)
            `FDCG_IDX_IRQ_SEL: next_rdata = {4'h0, irq_select};
            `FDCG_IDX_DMA_SEL: next_rdata = {5'h00, dma_select};
            `FDCG_IDX_MODE:    next_rdata = floppy_mode_config;
            `FDCG_IDX_OPTION:  next_rdata = floppy_option_config;
            `FDCG_IDX_TYPE:    next_rdata = floppy_drive_type_store;
            // RL19 reads zero
            `FDCG_IDX_RSVD:    next_rdata = 8'h00;
            // RL20 masked fields
            `FDCG_IDX_DRIVE0:  next_rdata = first_drive_settings & `FDCG_DRIVE_WMASK;
            `FDCG_IDX_DRIVE1:  next_rdata = second_drive_settings & `FDCG_DRIVE_WMASK;
            default:           next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata  <= 8'h00;
            cfg_rvalid <= 1'b0;
        end else if (ce) begin
            cfg_rvalid <= cfg_rd & cfg_sel;
            if (cfg_rd && cfg_sel) begin
                cfg_rdata <= next_rdata;
            end
        end
    end

    // gating terms
    always @* begin
        // RL23 nonzero irq select
        irq_sel_ok = (irq_select != 4'h0);
        // RL24 channel 1..3 only
        dma_sel_ok = (dma_select >= `FDCG_DMA_FIRST) && (dma_select <= `FDCG_DMA_LAST);
        // RL1 dma gate bit
        // RL2 power-down
        fdc_local_on = floppy_dma_gate_bit & ~floppy_powered_down;
        // RL5 spp and epp use printer gate
        pp_irq_enable = printer_irq_gate_bit;
        if (pp_ecp_enabled) begin
            // RL7 ecr mode table
            case (ecr_mode)
                `FDCG_ECR_FIFO: pp_irq_enable = 1'b1;
                `FDCG_ECR_ECP:  pp_irq_enable = 1'b1;
                `FDCG_ECR_TEST: pp_irq_enable = 1'b1;
                default:        pp_irq_enable = printer_irq_gate_bit;
            endcase
        end
    end

    // write protect and density
    always @* begin
        // RL15 forced when any drive selected
        next_wp = (~drive_select_first_n & floppy_option_config[`FDCG_OPT_FWP])
                | (~drive_select_second_n & floppy_option_config[`FDCG_OPT_FWP])
                | ~wp_pin_n
                | floppy_wp_bit;
        // RL17 density override
        case (dens_code)
            `FDCG_DENS_FORCE_ONE:  next_density = 1'b1;
            `FDCG_DENS_FORCE_ZERO: next_density = 1'b0;
            default:               next_density = density_core;
        endcase
    end

    // registered gated requests; one cycle behind the cores
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            floppy_irq_out <= 1'b0;
            floppy_dma_out <= 1'b0;
            ir_dma_out     <= 1'b0;
            pp_irq_out     <= 1'b0;
            pp_dma_out     <= 1'b0;
        end else if (ce) begin
            // RL1 floppy gating
            // RL2 floppy gating
            floppy_irq_out <= floppy_irq_req & fdc_local_on & irq_sel_ok;
            floppy_dma_out <= floppy_dma_req & fdc_local_on & dma_sel_ok;
            // RL4 infrared dma gate
            ir_dma_out     <= ir_dma_req & ir_dma_gate_bit;
            pp_irq_out     <= pp_irq_req & pp_irq_enable;
            // RL6 ecp dma gate, no dma outside ecp
            pp_dma_out     <= pp_dma_req & ecp_dma_gate_bit & pp_ecp_enabled;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_serial
            // RL3 aux output two gate
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    serial_irq_out[gi] <= 1'b0;
                end else if (ce) begin
                    serial_irq_out[gi] <= serial_irq_req[gi] & aux_output_two_bit[gi];
                end
            end
        end
    endgenerate

    // drive pins: open-drain drives only lows
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_out    <= 8'h00;
            drive_out_oe <= 8'h00;
        end else if (ce) begin
            // RL13 tri-state all drive outputs
            if (floppy_mode_config[`FDCG_MODE_TRISTATE]) begin
                drive_out    <= 8'h00;
                drive_out_oe <= 8'h00;
            // RL12 push-pull
            end else if (floppy_mode_config[`FDCG_MODE_PUSHPULL]) begin
                drive_out    <= drive_out_core;
                drive_out_oe <= 8'hff;
            // RL12 open-drain
            end else begin
                drive_out    <= 8'h00;
                drive_out_oe <= ~drive_out_core;
            end
        end
    end

    // decoded configuration towards the floppy core
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            core_write_protect <= 1'b0;
            floppy_status_a_wp <= 1'b0;
            density_out        <= 1'b0;
            enhanced_mode      <= 1'b0;
            dma_non_burst      <= 1'b1;
            interface_mode     <= 2'h3;
            drive_type_a       <= 2'h3;
            drive_type_b       <= 2'h3;
            drive_type_sel_0   <= 2'h0;
            rate_table_sel_0   <= 2'h0;
            precomp_disable_0  <= 1'b0;
            drive_type_sel_1   <= 2'h0;
            rate_table_sel_1   <= 2'h0;
            precomp_disable_1  <= 1'b0;
            floppy_irq_level   <= 4'h0;
            floppy_dma_channel <= 3'h0;
        end else if (ce) begin
            core_write_protect <= next_wp;
            // RL16 same term to status a
            floppy_status_a_wp <= next_wp;
            density_out        <= next_density;
            // RL9 enhanced mode
            enhanced_mode      <= floppy_mode_config[`FDCG_MODE_ENH];
            // RL10 burst select
            dma_non_burst      <= floppy_mode_config[`FDCG_MODE_NONBURST];
            // RL11 interface mode, reserved code passed as is
            interface_mode     <= floppy_mode_config[`FDCG_MODE_IF_HI:`FDCG_MODE_IF_LO];
            // RL18 drive type fields
            drive_type_a       <= floppy_drive_type_store[1:0];
            drive_type_b       <= floppy_drive_type_store[3:2];
            // RL20 per-drive fields
            drive_type_sel_0   <= first_drive_settings[`FDCG_DRV_TYPE_HI:`FDCG_DRV_TYPE_LO];
            rate_table_sel_0   <= first_drive_settings[`FDCG_DRV_RATE_HI:`FDCG_DRV_RATE_LO];
            // RL21 precompensation disable
            precomp_disable_0  <= first_drive_settings[`FDCG_DRV_PRECOMP];
            // RL22 second drive
            drive_type_sel_1   <= second_drive_settings[`FDCG_DRV_TYPE_HI:`FDCG_DRV_TYPE_LO];
            rate_table_sel_1   <= second_drive_settings[`FDCG_DRV_RATE_HI:`FDCG_DRV_RATE_LO];
            precomp_disable_1  <= second_drive_settings[`FDCG_DRV_PRECOMP];
            // level and channel only shown while enabled
            floppy_irq_level   <= irq_sel_ok ? irq_select : 4'h0;
            floppy_dma_channel <= dma_sel_ok ? dma_select : 3'h0;
        end
    end

endmodule // fdcg_config

//--- rtl/fdcg_consts.vh
// constants for the floppy configuration and irq/dma gating block
// assumes 8-bit configuration index/data access, one clock domain
`ifndef FDCG_CONSTS_VH
`define FDCG_CONSTS_VH

// configuration indices
`define FDCG_IDX_IRQ_SEL      8'h70
`define FDCG_IDX_DMA_SEL      8'h74
`define FDCG_IDX_MODE         8'hf0
`define FDCG_IDX_OPTION       8'hf1
`define FDCG_IDX_TYPE         8'hf2
`define FDCG_IDX_RSVD         8'hf3
`define FDCG_IDX_DRIVE0       8'hf4
`define FDCG_IDX_DRIVE1       8'hf5

// reset values
`define FDCG_RST_IRQ_SEL      4'h6
`define FDCG_RST_DMA_SEL      3'h2
`define FDCG_RST_MODE         8'h0e
`define FDCG_RST_OPTION       8'h00
`define FDCG_RST_TYPE         8'hff
`define FDCG_RST_DRIVE        8'h00

// writable bits of the per-drive registers
`define FDCG_DRIVE_WMASK      8'h5b

// mode register fields
`define FDCG_MODE_ENH         0
`define FDCG_MODE_NONBURST    1
`define FDCG_MODE_IF_LO       2
`define FDCG_MODE_IF_HI       3
`define FDCG_MODE_PUSHPULL    6
`define FDCG_MODE_TRISTATE    7

// option register fields
`define FDCG_OPT_FWP          0
`define FDCG_OPT_DENS_LO      2
`define FDCG_OPT_DENS_HI      3

// density codes
`define FDCG_DENS_FORCE_ONE   2'h2
`define FDCG_DENS_FORCE_ZERO  2'h3

// per-drive fields
`define FDCG_DRV_TYPE_LO      0
`define FDCG_DRV_TYPE_HI      1
`define FDCG_DRV_RATE_LO      3
`define FDCG_DRV_RATE_HI      4
`define FDCG_DRV_PRECOMP      6

// ecr mode codes with interrupt always on
`define FDCG_ECR_FIFO         3'h2
`define FDCG_ECR_ECP          3'h3
`define FDCG_ECR_TEST         3'h6

// dma channel select range that activates a channel
`define FDCG_DMA_FIRST        3'h1
`define FDCG_DMA_LAST         3'h3

`endif

//--- rtl/fdcg_sync.v
// three-stage synchroniser for pin inputs
// assumes inputs are asynchronous to clk; output moves when stages 2 and 3 agree
`timescale 1ns/100ps

module fdcg_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    input  wire [W-1:0] d,
    input  wire [W-1:0] init,
    output reg  [W-1:0] q
);

    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    reg         primed;

    // s1 feeds s2 only; the agreement check looks at s2 and s3
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1     <= {W{1'b0}};
            s2     <= {W{1'b0}};
            s3     <= {W{1'b0}};
            q      <= {W{1'b0}};
            primed <= 1'b0;
        end else if (ce) begin
            s1 <= d;
            // priming loads the idle level into both compare stages,
            // otherwise the cleared stages fake a change after reset
            if (!primed) begin
                s2     <= init;
                s3     <= init;
                q      <= init;
                primed <= 1'b1;
            end else begin
                s2 <= s1;
                s3 <= s2;
                q  <= (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
            end
        end
    end

endmodule // fdcg_sync

//--- sim/fdcg_checker.sv
// checker for the floppy configuration and irq/dma gating block
// bound to every fdcg_config instance; sees its ports only, one clock domain
`timescale 1ns/100ps
`include "fdcg_consts.vh"

module fdcg_checker (
    input wire       clk,
    input wire       rst,
    input wire       ce,
    input wire       cfg_sel,
    input wire       cfg_rd,
    input wire       cfg_rvalid,
    input wire       floppy_dma_gate_bit,
    input wire       floppy_powered_down,
    input wire       floppy_irq_req,
    input wire       floppy_dma_req,
    input wire       floppy_irq_out,
    input wire       floppy_dma_out,
    input wire [3:0] floppy_irq_level,
    input wire [2:0] floppy_dma_channel,
    input wire [1:0] aux_output_two_bit,
    input wire [1:0] serial_irq_req,
    input wire [1:0] serial_irq_out,
    input wire       ir_dma_gate_bit,
    input wire       ir_dma_req,
    input wire       ir_dma_out,
    input wire       pp_ecp_enabled,
    input wire [2:0] ecr_mode,
    input wire       printer_irq_gate_bit,
    input wire       ecp_dma_gate_bit,
    input wire       pp_irq_req,
    input wire       pp_dma_req,
    input wire       pp_irq_out,
    input wire       pp_dma_out,
    input wire       core_write_protect,
    input wire       floppy_status_a_wp,
    input wire [7:0] drive_out_core,
    input wire [7:0] drive_out,
    input wire [7:0] drive_out_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // outputs lag inputs by one enabled edge; skip the edge leaving reset
    sequence live;
        $past(ce) && !$past(rst);
    endsequence

    floppy_irq_gate_a: assert property (live |-> floppy_irq_out == ($past(floppy_irq_req && floppy_dma_gate_bit
        && !floppy_powered_down) && floppy_irq_level != 4'h0)) else $error("floppy irq gating wrong");
    floppy_dma_gate_a: assert property (live |-> floppy_dma_out == ($past(floppy_dma_req && floppy_dma_gate_bit
        && !floppy_powered_down) && floppy_dma_channel >= `FDCG_DMA_FIRST && floppy_dma_channel <= `FDCG_DMA_LAST))
        else $error("floppy dma gating wrong");
    serial_irq_gate_a: assert property (live |-> serial_irq_out == $past(serial_irq_req & aux_output_two_bit))
        else $error("serial irq gating wrong");
    ir_dma_gate_a: assert property (live |-> ir_dma_out == $past(ir_dma_req && ir_dma_gate_bit))
        else $error("infrared dma gating wrong");
    pp_irq_gate_a: assert property (live |-> pp_irq_out == $past(pp_irq_req && (printer_irq_gate_bit
        || pp_ecp_enabled && (ecr_mode == `FDCG_ECR_FIFO || ecr_mode == `FDCG_ECR_ECP || ecr_mode == `FDCG_ECR_TEST))))
        else $error("parallel irq gating wrong");
    pp_dma_gate_a: assert property (live |-> pp_dma_out == $past(pp_dma_req && ecp_dma_gate_bit && pp_ecp_enabled))
        else $error("parallel dma gating wrong");
    status_wp_copy_a: assert property (floppy_status_a_wp == core_write_protect)
        else $error("status write protect differs");
    drive_pin_kind_a: assert property (live ##0 drive_out_oe != 8'h00 |->
        (drive_out_oe == 8'hff && drive_out == $past(drive_out_core)) || (drive_out == 8'h00 && drive_out_oe == ~$past(drive_out_core)))
        else $error("drive pin drive kind wrong");
    read_answer_a: assert property (live |-> cfg_rvalid == $past(cfg_sel && cfg_rd))
        else $error("read answer timing wrong");

    cover property (floppy_irq_out && floppy_dma_out);
    cover property (pp_irq_out && !printer_irq_gate_bit);
    cover property (drive_out_oe == 8'h00);
endmodule // fdcg_checker

bind fdcg_config fdcg_checker fdcg_checker_i (.*);

//--- sim/fdcg_config_tb.sv
// self-checking bench for the floppy configuration and irq/dma gating block
// drives every port directly; clk 250 MHz, reset held 10 cycles
`timescale 1ns/100ps
`include "fdcg_consts.vh"

module fdcg_config_tb;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        ce = 1'b1;
    reg        soft_rst = 1'b0, cfg_sel = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
    reg  [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, drive_out_core = 8'ha5;
    reg        floppy_dma_gate_bit = 1'b1, floppy_powered_down = 1'b0, floppy_irq_req = 1'b1, floppy_dma_req = 1'b1;
    reg  [1:0] aux_output_two_bit = 2'h1, serial_irq_req = 2'h3;
    reg        ir_dma_gate_bit = 1'b0, ir_dma_req = 1'b1, pp_ecp_enabled = 1'b0, printer_irq_gate_bit = 1'b0;
    reg        ecp_dma_gate_bit = 1'b1, pp_irq_req = 1'b1, pp_dma_req = 1'b1, write_protect_in_n = 1'b1;
    reg        floppy_wp_bit = 1'b0, drive_select_first_n = 1'b1, drive_select_second_n = 1'b1, density_core = 1'b0;
    reg  [2:0] ecr_mode = 3'h0;
    wire [7:0] cfg_rdata, drive_out, drive_out_oe;
    wire [3:0] floppy_irq_level;
    wire [2:0] floppy_dma_channel;
    wire [1:0] serial_irq_out, interface_mode, drive_type_a, drive_type_b;
    wire [1:0] drive_type_sel_0, rate_table_sel_0, drive_type_sel_1, rate_table_sel_1;
    wire       cfg_rvalid, floppy_irq_out, floppy_dma_out, ir_dma_out, pp_irq_out, pp_dma_out, core_write_protect;
    wire       floppy_status_a_wp, density_out, enhanced_mode, dma_non_burst, precomp_disable_0, precomp_disable_1;
    integer    fail_count = 0;
    integer    check_count = 0;
    integer    i;
    reg  [7:0] ridx [0:8];
    reg  [7:0] rexp [0:8];

    fdcg_config fdcg_config_i (.*);

    always #2 clk = ~clk;

    task report_and_stop;
        begin
            if (fail_count == 0 && check_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task chk(input [7:0] seen, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task wr(input sel, input [7:0] idx, input [7:0] d);
        begin
            @(posedge clk);
            cfg_sel <= sel;
            cfg_wr <= 1'b1;
            cfg_index <= idx;
            cfg_wdata <= d;
            @(posedge clk);
            cfg_sel <= 1'b0;
            cfg_wr <= 1'b0;
        end
    endtask

    task rd(input [7:0] idx, input [7:0] exp);
        begin
            @(posedge clk);
            cfg_sel <= 1'b1;
            cfg_rd <= 1'b1;
            cfg_index <= idx;
            @(posedge clk);
            cfg_sel <= 1'b0;
            cfg_rd <= 1'b0;
            #1;
            chk(cfg_rvalid, 8'h01);
            chk(cfg_rdata, exp);
        end
    endtask

    // covers pin sync and gating latency
    task settle;
        begin
            repeat (6) @(posedge clk);
            #1;
        end
    endtask

    initial begin
        #100000;
        fail_count = fail_count + 1;
        report_and_stop;
    end

    initial begin
        ridx = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'h70, 8'h74, 8'h80};
        rexp = '{8'h0e, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h06, 8'h02, 8'h00};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 9; i = i + 1)
            rd(ridx[i], rexp[i]);
        chk({enhanced_mode, dma_non_burst, interface_mode}, 8'h07);
        chk({drive_type_a, drive_type_b}, 8'h0f);
        chk({floppy_irq_out, floppy_dma_out}, 8'h03);
        chk({floppy_irq_level, 1'b0, floppy_dma_channel}, 8'h62);
        // deselected write ignored
        wr(1'b1, 8'hf0, 8'h51);
        wr(1'b0, 8'hf0, 8'hff);
        rd(8'hf0, 8'h51);
        chk({enhanced_mode, dma_non_burst, interface_mode}, 8'h08);
        chk(drive_out, 8'ha5);
        chk(drive_out_oe, 8'hff);
        wr(1'b1, 8'hf0, 8'h88);
        rd(8'hf0, 8'h88);
        chk(interface_mode, 8'h02);
        chk(drive_out_oe, 8'h00);
        wr(1'b1, 8'hf0, 8'h06);
        settle;
        chk({dma_non_burst, interface_mode}, 8'h05);
        chk(drive_out, 8'h00);
        chk(drive_out_oe, 8'h5a);
        wr(1'b1, 8'hf4, 8'hff);
        rd(8'hf4, 8'h5b);
        chk({drive_type_sel_0, rate_table_sel_0, precomp_disable_0}, 8'h1f);
        wr(1'b1, 8'hf5, 8'h48);
        rd(8'hf5, 8'h48);
        chk({drive_type_sel_1, rate_table_sel_1, precomp_disable_1}, 8'h03);
        wr(1'b1, 8'hf2, 8'h9c);
        rd(8'hf2, 8'h9c);
        chk({drive_type_a, drive_type_b}, 8'h03);
        wr(1'b1, 8'hf3, 8'hff);
        rd(8'hf3, 8'h00);
        // write while clock enable is low is frozen out
        @(posedge clk);
        ce <= 1'b0;
        wr(1'b1, 8'hf2, 8'h00);
        ce <= 1'b1;
        rd(8'hf2, 8'h9c);
        @(posedge clk);
        floppy_dma_gate_bit <= 1'b0;
        settle;
        chk({floppy_irq_out, floppy_dma_out}, 8'h00);
        @(posedge clk);
        floppy_dma_gate_bit <= 1'b1;
        floppy_powered_down <= 1'b1;
        settle;
        chk({floppy_irq_out, floppy_dma_out}, 8'h00);
        @(posedge clk);
        floppy_powered_down <= 1'b0;
        wr(1'b1, 8'h70, 8'h00);
        wr(1'b1, 8'h74, 8'h03);
        settle;
        chk({floppy_irq_out, floppy_dma_out}, 8'h01);
        chk(floppy_dma_channel, 8'h03);
        wr(1'b1, 8'h74, 8'h04);
        settle;
        chk({floppy_dma_out, floppy_dma_channel}, 8'h00);
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        rd(8'h70, 8'h06);
        rd(8'h74, 8'h02);
        rd(8'hf0, 8'h06);
        rd(8'hf4, 8'h5b);
        chk({serial_irq_out, ir_dma_out}, 8'h02);
        chk({pp_irq_out, pp_dma_out}, 8'h00);
        @(posedge clk);
        aux_output_two_bit <= 2'h2;
        ir_dma_gate_bit <= 1'b1;
        printer_irq_gate_bit <= 1'b1;
        settle;
        chk({serial_irq_out, ir_dma_out}, 8'h05);
        chk(pp_irq_out, 8'h01);
        @(posedge clk);
        printer_irq_gate_bit <= 1'b0;
        pp_ecp_enabled <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk);
            ecr_mode <= i[2:0];
            ecp_dma_gate_bit <= i[0];
            settle;
            chk({pp_irq_out, pp_dma_out}, {6'h00, i == 2 || i == 3 || i == 6, i[0]});
        end
        wr(1'b1, 8'hf1, 8'hf1);
        rd(8'hf1, 8'hf1);
        @(posedge clk);
        drive_select_first_n <= 1'b0;
        settle;
        chk({core_write_protect, floppy_status_a_wp}, 8'h03);
        @(posedge clk);
        drive_select_first_n <= 1'b1;
        drive_select_second_n <= 1'b0;
        settle;
        chk({core_write_protect, floppy_status_a_wp}, 8'h03);
        wr(1'b1, 8'hf1, 8'h08);
        settle;
        chk({core_write_protect, floppy_status_a_wp, density_out}, 8'h01);
        @(posedge clk);
        write_protect_in_n <= 1'b0;
        settle;
        chk({core_write_protect, floppy_status_a_wp}, 8'h03);
        @(posedge clk);
        write_protect_in_n <= 1'b1;
        floppy_wp_bit <= 1'b1;
        density_core <= 1'b1;
        wr(1'b1, 8'hf1, 8'h0c);
        settle;
        chk({core_write_protect, density_out}, 8'h02);
        wr(1'b1, 8'hf1, 8'h04);
        settle;
        chk(density_out, 8'h01);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'hf0, 8'h0e);
        rd(8'hf4, 8'h00);
        report_and_stop;
    end
endmodule // fdcg_config_tb
